// file: act_conv_timing.sv
// Converter conversion timing sequencer: start-up, sampling, hold, conversion
`timescale 1ns/1ps
module act_conv_timing (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire act_pkg::act_cfg_t     cfg_in,
  input  wire logic                  start_in,
  output act_pkg::act_analog_t       analog_out,
  output logic                       converter_busy_flag_out,
  output logic                       result_valid_out,
  output logic [10:0]                sample_index_out
);

  act_pkg::act_state_t state_q, state_d;
  logic        half_tick;
  logic        us_tick;
  logic [9:0]  cnt_q;
  logic [9:0]  load_d;
  logic [4:0]  cyc_q;
  logic [10:0] samp_cnt_q;
  logic [10:0] samp_total;
  logic        last_sample;
  logic        pending_q;
  logic        ready_q;
  logic        init_amp_q;
  logic [2:0]  init_ref_q;
  logic [1:0]  init_src_q;
  logic        keep_on;
  logic        ref_int;
  logic        src_int;
  logic        slow_clk;
  logic        core_new, amp_new, ref_new, src_new, ref_fast;
  logic        need_init;
  logic [6:0]  init_us;
  logic [6:0]  hold_us;
  logic [9:0]  samp_halves;
  logic [9:0]  conv_halves;
  logic        powered_d;
  logic [3:0]  acc_field;

  // Prescaled converter clock and microsecond timebase
  act_tick_gen u_ticks (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .divider_in    (cfg_in.converter_clock_divider),
    .timebase_in   (cfg_in.timebase_field),
    .half_tick_out (half_tick),
    .us_tick_out   (us_tick)
  );

  assign keep_on  = cfg_in.low_latency_keep_on;
  assign ref_int  = cfg_in.ref_select != act_pkg::REF_SUPPLY;
  assign src_int  = cfg_in.input_source != act_pkg::SRC_PIN;
  // Timebase is peripheral clocks per us, so it doubles as clock rate in MHz
  assign slow_clk = cfg_in.timebase_field < act_pkg::SLOW_CLK_MHZ;

  // Which modules still need start-up; with low latency only fresh ones do
  always_comb begin
    core_new = !(keep_on && ready_q);
    amp_new  = cfg_in.amp_enable && !(keep_on && ready_q && init_amp_q);
    ref_new  = ref_int && !(keep_on && ready_q && init_ref_q == cfg_in.ref_select);
    src_new  = src_int && !(keep_on && ready_q && init_src_q == cfg_in.input_source);
    ref_fast = keep_on && ready_q && init_ref_q != act_pkg::REF_SUPPLY;
    need_init = core_new || amp_new || ref_new || src_new;
  end

  // Longest start-up among the modules that need it, in microseconds
  always_comb begin
    init_us = 7'h00;
    if (core_new && !slow_clk && init_us < act_pkg::CORE_INIT_US) begin
      init_us = act_pkg::CORE_INIT_US;
    end
    if (amp_new && init_us < act_pkg::AMP_INIT_US) begin
      init_us = act_pkg::AMP_INIT_US;
    end
    if (src_new && init_us < act_pkg::SRC_INIT_US) begin
      init_us = act_pkg::SRC_INIT_US;
    end
    if (ref_new && ref_fast && init_us < act_pkg::REF_FAST_US) begin
      init_us = act_pkg::REF_FAST_US;
    end
    if (ref_new && !ref_fast && init_us < act_pkg::REF_INIT_US) begin
      init_us = act_pkg::REF_INIT_US;
    end
  end

  // Hold time follows amplifier bias
  always_comb begin
    case (cfg_in.amp_bias_select)
      act_pkg::BIAS_FULL:          hold_us = ref_int ? act_pkg::HOLD_FULL_REF_US
                                                     : act_pkg::HOLD_FULL_US;
      act_pkg::BIAS_THREE_QUARTER: hold_us = act_pkg::HOLD_3Q_US;
      act_pkg::BIAS_HALF:          hold_us = act_pkg::HOLD_HALF_US;
      act_pkg::BIAS_QUARTER:       hold_us = act_pkg::HOLD_QUARTER_US;
      default:                     hold_us = act_pkg::HOLD_QUARTER_US;
    endcase
  end

  // Phase lengths in converter half cycles
  always_comb begin
    if (cfg_in.amp_enable) begin
      samp_halves = 10'(({2'h0, cfg_in.sample_duration_field} + 10'h001) << 1);
    end else begin
      samp_halves = 10'({1'b0, cfg_in.sample_duration_field, 1'b1});
    end
    if (cfg_in.eight_bit && cfg_in.conv_mode == act_pkg::MODE_SINGLE) begin
      conv_halves = act_pkg::CONV_HALVES_8BIT;
    end else begin
      conv_halves = act_pkg::CONV_HALVES_STD;
    end
  end

  // Sample count per result; larger field values clamp to 1024
  always_comb begin
    acc_field = (cfg_in.accumulate_count_field > act_pkg::ACC_FIELD_MAX) ? act_pkg::ACC_FIELD_MAX
                                                                          : cfg_in.accumulate_count_field;
    if (cfg_in.conv_mode == act_pkg::MODE_SINGLE) begin
      samp_total = 11'h001;
    end else begin
      samp_total = 11'(11'h001 << acc_field);
    end
    last_sample = (samp_cnt_q + 11'h001) >= samp_total;
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      act_pkg::ST_IDLE: begin
        if (cfg_in.enable && keep_on && need_init) begin
          state_d = act_pkg::ST_INIT;
        end else if (cfg_in.enable && start_in) begin
          state_d = need_init ? act_pkg::ST_INIT : act_pkg::ST_SAMPLE;
        end
      end
      act_pkg::ST_INIT: begin
        if (cnt_q == 10'h000 && cyc_q == 5'h00) begin
          state_d = (pending_q || start_in) ? act_pkg::ST_SAMPLE : act_pkg::ST_IDLE;
        end
      end
      act_pkg::ST_SAMPLE: begin
        if (cnt_q == 10'h000) begin
          state_d = cfg_in.amp_enable ? act_pkg::ST_HOLD : act_pkg::ST_CONV;
        end
      end
      act_pkg::ST_HOLD: begin
        if (cnt_q == 10'h000) begin
          state_d = act_pkg::ST_CONV;
        end
      end
      act_pkg::ST_CONV: begin
        if (cnt_q == 10'h000) begin
          state_d = act_pkg::ST_RESULT;
        end
      end
      act_pkg::ST_RESULT: begin
        if (cnt_q == 10'h000) begin
          if (!last_sample) begin
            state_d = (cfg_in.conv_mode == act_pkg::MODE_BURST) ? act_pkg::ST_SAMPLE : act_pkg::ST_IDLE;
          end else if (cfg_in.continuous_restart_bit) begin
            state_d = need_init ? act_pkg::ST_INIT : act_pkg::ST_SAMPLE;
          end else begin
            state_d = act_pkg::ST_IDLE;
          end
        end
      end
      default: state_d = act_pkg::ST_IDLE;
    endcase
    if (!cfg_in.enable) begin
      state_d = act_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= act_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Phase length loaded on entry to each timed state
  always_comb begin
    case (state_d)
      act_pkg::ST_INIT:   load_d = {3'h0, init_us};
      act_pkg::ST_SAMPLE: load_d = samp_halves;
      act_pkg::ST_HOLD:   load_d = {3'h0, hold_us};
      act_pkg::ST_CONV:   load_d = conv_halves;
      act_pkg::ST_RESULT: load_d = act_pkg::RESULT_HALVES;
      default:            load_d = 10'h000;
    endcase
  end

  // One down-counter; microsecond ticks in start-up and hold, half cycles elsewhere
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= 10'h000;
    end else if (state_d != state_q) begin
      cnt_q <= load_d;
    end else if (cnt_q != 10'h000) begin
      if ((state_q == act_pkg::ST_INIT || state_q == act_pkg::ST_HOLD) ? us_tick : half_tick) begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end

  // Slow-clock core start-up runs beside the microsecond count
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cyc_q <= 5'h00;
    end else if (state_d == act_pkg::ST_INIT && state_q != act_pkg::ST_INIT) begin
      cyc_q <= (core_new && slow_clk) ? act_pkg::CORE_SLOW_CYCLES : 5'h00;
    end else if (cyc_q != 5'h00) begin
      cyc_q <= cyc_q - 5'h01;
    end
  end

  // Trigger seen on entry to start-up, or a restart from result; cleared on sample or idle
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pending_q <= 1'b0;
    end else if ((state_q == act_pkg::ST_IDLE && state_d == act_pkg::ST_INIT && start_in) ||
                 (state_q == act_pkg::ST_RESULT && state_d == act_pkg::ST_INIT)) begin
      pending_q <= 1'b1;
    end else if (state_d == act_pkg::ST_SAMPLE || state_d == act_pkg::ST_IDLE) begin
      pending_q <= 1'b0;
    end
  end

  // Configuration that the powered modules were started for
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_q    <= 1'b0;
      init_amp_q <= 1'b0;
      init_ref_q <= act_pkg::REF_SUPPLY;
      init_src_q <= act_pkg::SRC_PIN;
    end else if (!cfg_in.enable || !keep_on) begin
      ready_q <= 1'b0;
    end else if (state_q == act_pkg::ST_INIT && state_d != act_pkg::ST_INIT) begin
      ready_q    <= 1'b1;
      init_amp_q <= cfg_in.amp_enable;
      init_ref_q <= cfg_in.ref_select;
      init_src_q <= cfg_in.input_source;
    end
  end

  // Samples gathered toward the current result
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      samp_cnt_q <= 11'h000;
    end else if (!cfg_in.enable) begin
      samp_cnt_q <= 11'h000;
    end else if (state_q == act_pkg::ST_RESULT && cnt_q == 10'h000) begin
      samp_cnt_q <= last_sample ? 11'h000 : samp_cnt_q + 11'h001;
    end
  end

  // Powered between conversions only when low latency holds a finished start-up
  assign powered_d = cfg_in.enable && (state_d != act_pkg::ST_IDLE || (keep_on && ready_q));

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      analog_out <= '0;
    end else begin
      analog_out.core_power   <= powered_d;
      analog_out.amp_power    <= powered_d && cfg_in.amp_enable;
      analog_out.ref_power    <= powered_d && ref_int;
      analog_out.src_power    <= powered_d && src_int;
      analog_out.amp_sampling <= powered_d && cfg_in.amp_enable && state_d != act_pkg::ST_HOLD;
      analog_out.amp_hold     <= state_d == act_pkg::ST_HOLD;
      // Only a kick; the buffer times itself, so duration stays software's job
      analog_out.ref_autozero <= state_d == act_pkg::ST_SAMPLE && state_q != act_pkg::ST_SAMPLE &&
                                 ref_int && !cfg_in.amp_enable;
      analog_out.sampling     <= state_d == act_pkg::ST_SAMPLE;
      analog_out.converting   <= state_d == act_pkg::ST_CONV;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      converter_busy_flag_out <= 1'b0;
      result_valid_out        <= 1'b0;
      sample_index_out        <= 11'h000;
    end else begin
      converter_busy_flag_out <= state_d == act_pkg::ST_INIT;
      result_valid_out        <= state_q == act_pkg::ST_RESULT && cnt_q == 10'h000 && last_sample;
      sample_index_out        <= samp_cnt_q;
    end
  end

  // Ticks seen in the current state, for the checks below
  logic [9:0] seen_q;
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      seen_q <= 10'h000;
    end else if (state_d != state_q) begin
      seen_q <= 10'h000;
    end else if (cnt_q != 10'h000 &&
                 ((state_q == act_pkg::ST_INIT || state_q == act_pkg::ST_HOLD) ? us_tick : half_tick)) begin
      seen_q <= seen_q + 10'h001;
    end
  end

  busy_tracks_init_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    converter_busy_flag_out == (state_q == act_pkg::ST_INIT))
    else $error("busy flag does not match start-up state");

  power_off_idle_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == act_pkg::ST_IDLE && !$past(keep_on)) |-> !analog_out.core_power)
    else $error("core powered between conversions without low latency");

  keep_on_idle_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ($past(keep_on && ready_q && cfg_in.enable) && state_q == act_pkg::ST_IDLE) |-> analog_out.core_power)
    else $error("low latency did not keep modules powered");

  conv_length_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == act_pkg::ST_CONV && state_d == act_pkg::ST_RESULT) |->
      seen_q == ((cfg_in.eight_bit && cfg_in.conv_mode == act_pkg::MODE_SINGLE) ? 10'h012 : 10'h01A))
    else $error("conversion phase length wrong");

  plain_sample_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == act_pkg::ST_SAMPLE && state_d == act_pkg::ST_CONV && $stable(cfg_in)) |->
      seen_q == 10'({1'b0, cfg_in.sample_duration_field, 1'b1}))
    else $error("direct sampling length wrong");

  amp_sample_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == act_pkg::ST_SAMPLE && state_d == act_pkg::ST_HOLD && $stable(cfg_in)) |->
      seen_q == 10'({1'b0, cfg_in.sample_duration_field, 1'b0} + 10'h002))
    else $error("amplifier input sampling length wrong");

  hold_length_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == act_pkg::ST_HOLD && state_d == act_pkg::ST_CONV && $stable(cfg_in)) |->
      seen_q == ((cfg_in.amp_bias_select == 2'h3) ? 10'h00C : (cfg_in.amp_bias_select == 2'h2) ? 10'h006 :
                 (cfg_in.amp_bias_select == 2'h1) ? 10'h005 : (ref_int ? 10'h004 : 10'h003)))
    else $error("amplifier hold length wrong");

  hold_stops_amp_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    analog_out.amp_hold |-> !analog_out.amp_sampling ##1 (analog_out.amp_hold || analog_out.converting))
    else $error("amplifier sampled during hold");

  core_init_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ($rose(converter_busy_flag_out) && !$past(ready_q) && !slow_clk && $stable(cfg_in)) |->
      cnt_q >= 10'h00A)
    else $error("core start-up shorter than 10 us");

  restart_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (result_valid_out && cfg_in.continuous_restart_bit && cfg_in.enable && $stable(cfg_in)) |->
      (analog_out.sampling || converter_busy_flag_out))
    else $error("continuous restart did not begin next conversion");

endmodule // act_conv_timing

// file: act_pkg.sv
// Shared constants and carrier types for the converter timing sequencer
package act_pkg;

  // Microsecond figures for module start-up and amplifier hold
  localparam logic [6:0] CORE_INIT_US     = 7'h0A;  // 10 us
  localparam logic [6:0] AMP_INIT_US      = 7'h14;  // 20 us
  localparam logic [6:0] REF_INIT_US      = 7'h3C;  // 60 us
  localparam logic [6:0] REF_FAST_US      = 7'h02;  // 2 us, internal to internal
  localparam logic [6:0] SRC_INIT_US      = 7'h23;  // 35 us
  localparam logic [6:0] HOLD_FULL_US     = 7'h03;  // 3 us
  localparam logic [6:0] HOLD_FULL_REF_US = 7'h04;  // 4 us with internal reference
  localparam logic [6:0] HOLD_3Q_US       = 7'h05;  // 5 us
  localparam logic [6:0] HOLD_HALF_US     = 7'h06;  // 6 us
  localparam logic [6:0] HOLD_QUARTER_US  = 7'h0C;  // 12 us

  // Core start-up counted in peripheral clocks on a slow clock
  localparam logic [4:0] CORE_SLOW_CYCLES = 5'h14;  // 20 cycles
  localparam logic [6:0] SLOW_CLK_MHZ     = 7'h02;  // below 2 MHz

  // Conversion state lengths in converter half cycles
  localparam logic [9:0] CONV_HALVES_8BIT = 10'h012; // 9 cycles
  localparam logic [9:0] CONV_HALVES_STD  = 10'h01A; // 13 cycles
  localparam logic [9:0] RESULT_HALVES    = 10'h001; // half a cycle
  localparam logic [3:0] ACC_FIELD_MAX    = 4'hA;    // 1024 samples

  // Field encodings
  localparam logic [2:0] REF_SUPPLY       = 3'h0;
  localparam logic [1:0] SRC_PIN          = 2'h0;
  localparam logic [1:0] MODE_SINGLE      = 2'h0;
  localparam logic [1:0] MODE_SERIES      = 2'h1;
  localparam logic [1:0] MODE_BURST       = 2'h2;
  localparam logic [1:0] BIAS_FULL        = 2'h0;
  localparam logic [1:0] BIAS_THREE_QUARTER = 2'h1;
  localparam logic [1:0] BIAS_HALF        = 2'h2;
  localparam logic [1:0] BIAS_QUARTER     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT, ST_SAMPLE, ST_HOLD, ST_CONV, ST_RESULT
  } act_state_t;

  typedef struct packed {
    logic       enable;
    logic       low_latency_keep_on;
    logic       amp_enable;
    logic [1:0] amp_bias_select;
    logic [2:0] ref_select;
    logic [1:0] input_source;
    logic [1:0] conv_mode;
    logic       eight_bit;
    logic [7:0] sample_duration_field;
    logic [3:0] accumulate_count_field;
    logic       continuous_restart_bit;
    logic [3:0] converter_clock_divider;
    logic [6:0] timebase_field;
  } act_cfg_t;

  typedef struct packed {
    logic core_power;
    logic amp_power;
    logic ref_power;
    logic src_power;
    logic amp_sampling;
    logic amp_hold;
    logic ref_autozero;
    logic sampling;
    logic converting;
  } act_analog_t;

endpackage

// file: act_tick_gen.sv
// Converter half-cycle and microsecond tick generator
`timescale 1ns/1ps
module act_tick_gen (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic [3:0] divider_in,
  input  wire logic [6:0] timebase_in,
  output logic            half_tick_out,
  output logic            us_tick_out
);

  logic [3:0] div_q;
  logic [6:0] tb_q;

  // Converter clock period is 2*(divider+1) peripheral clocks
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q         <= 4'h0;
      half_tick_out <= 1'b0;
    end else if (div_q >= divider_in) begin
      div_q         <= 4'h0;
      half_tick_out <= 1'b1;
    end else begin
      div_q         <= div_q + 4'h1;
      half_tick_out <= 1'b0;
    end
  end

  // Zero or one in the timebase gives a tick every clock
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tb_q        <= 7'h00;
      us_tick_out <= 1'b0;
    end else if (tb_q + 7'h01 >= timebase_in) begin
      tb_q        <= 7'h00;
      us_tick_out <= 1'b1;
    end else begin
      tb_q        <= tb_q + 7'h01;
      us_tick_out <= 1'b0;
    end
  end

endmodule // act_tick_gen

// file: act_analog_model.sv
// Converter core stand-in: measures phase lengths seen at the analog controls
`timescale 1ns/1ps
module act_analog_model (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  input  wire act_pkg::act_analog_t analog_in,
  input  wire logic                 busy_in,
  output logic [3:0][15:0]          len_out,
  output logic [15:0]               samp_rises_out,
  output logic                      hold_clash_out
);
  logic [3:0]       sig;
  logic [3:0]       sig_q;
  logic [3:0][15:0] cnt_q;
  assign sig = {analog_in.amp_hold, analog_in.converting, analog_in.sampling, busy_in};
  // Length of each level latched on its falling edge
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sig_q   <= 4'h0;
      cnt_q   <= '0;
      len_out <= '0;
    end else begin
      sig_q <= sig;
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= sig[i] ? cnt_q[i] + 16'h0001 : 16'h0000;
        if (sig_q[i] && !sig[i]) len_out[i] <= cnt_q[i];
      end
    end
  end
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      samp_rises_out <= 16'h0000;
      hold_clash_out <= 1'b0;
    end else begin
      if (sig[1] && !sig_q[1]) samp_rises_out <= samp_rises_out + 16'h0001;
      // The amplifier must not track its input while it holds its output
      if (analog_in.amp_hold && analog_in.amp_sampling) hold_clash_out <= 1'b1;
    end
  end
endmodule // act_analog_model

// file: act_conv_timing_tb.sv
// Self-checking bench for the converter timing sequencer
`timescale 1ns/1ps
module act_conv_timing_tb;
  logic                 clk;
  logic                 rst;
  logic                 start;
  logic                 busy;
  logic                 res;
  logic                 hold_clash;
  logic [3:0][15:0]     len;
  logic [15:0]          nsamp;
  logic [15:0]          n0;
  logic [15:0]          n_az;
  logic [15:0]          az0;
  logic [10:0]          sidx;
  act_pkg::act_cfg_t    cfg;
  act_pkg::act_cfg_t    base;
  act_pkg::act_analog_t ana;
  int                   n_errors;
  int                   samples_checked;
  act_conv_timing i_dut (.sys_clk_in(clk), .reset_in(rst), .cfg_in(cfg), .start_in(start), .analog_out(ana),
    .converter_busy_flag_out(busy), .result_valid_out(res), .sample_index_out(sidx));
  act_analog_model i_model (.sys_clk_in(clk), .reset_in(rst), .analog_in(ana), .busy_in(busy), .len_out(len),
    .samp_rises_out(nsamp), .hold_clash_out(hold_clash));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  // Autozero kicks seen at the reference buffer
  always @(posedge clk) begin
    if (rst) n_az <= 16'h0000;
    else if (ana.ref_autozero) n_az <= n_az + 16'h0001;
  end
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo[15:0], hi[15:0]);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic off();
    cfg.enable = 1'b0;
    tick(3);
  endtask
  task automatic wait_res();
    int k;
    k = 0;
    while (res !== 1'b1 && k < 5000) begin tick(1); k++; end
    chk(res, 1'b1);
  endtask
  task automatic conv(input act_pkg::act_cfg_t c);
    tick(1);
    cfg = c;
    start = 1'b1;
    n0 = nsamp;
    az0 = n_az;
    tick(1);
    start = 1'b0;
    wait_res();
  endtask
  task automatic wait_busy();
    int k;
    k = 0;
    tick(2);
    while (busy !== 1'b0 && k < 2000) begin tick(1); k++; end
    chk(busy, 1'b0);
    // Model latches the length one edge after the fall
    tick(1);
  endtask
  // Timebase 5 clocks per us; alignment allows one tick either way
  task automatic chk_us(input logic [15:0] got, input int us);
    chk_rng(got, us * 5 - 5, us * 5 + 5);
  endtask
  initial begin
    int us_hold [4];
    us_hold = '{3, 5, 6, 12};
    n_errors = 0;
    samples_checked = 0;
    start = 1'b0;
    base = '0;
    base.enable = 1'b1;
    base.timebase_field = 7'h05;
    base.sample_duration_field = 8'h04;
    cfg = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    conv(base);
    chk_us(len[0], 10);
    chk_rng(len[1], 9, 10);
    chk_rng(len[2], 26, 27);
    tick(2);
    chk(ana.core_power, 1'b0);
    off();
    cfg = base;
    cfg.eight_bit = 1'b1;
    conv(cfg);
    chk_rng(len[2], 18, 19);
    off();
    cfg = base;
    cfg.input_source = 2'h1;
    conv(cfg);
    chk_us(len[0], 35);
    off();
    cfg.enable = 1'b1;
    cfg.ref_select = 3'h1;
    conv(cfg);
    chk_us(len[0], 60);
    chk(n_az - az0, 16'h0001);
    off();
    for (int b = 0; b < 4; b++) begin
      cfg = base;
      cfg.amp_enable = 1'b1;
      cfg.amp_bias_select = b[1:0];
      conv(cfg);
      chk_us(len[0], 20);
      chk_rng(len[1], 10, 11);
      chk_us(len[3], us_hold[b]);
      off();
    end
    cfg.enable = 1'b1;
    cfg.amp_bias_select = act_pkg::BIAS_FULL;
    cfg.ref_select = 3'h1;
    conv(cfg);
    chk_us(len[3], 4);
    chk(hold_clash, 1'b0);
    chk(n_az - az0, 16'h0000);
    off();
    cfg = base;
    cfg.timebase_field = 7'h01;
    conv(cfg);
    chk_rng(len[0], 20, 22);
    off();
    cfg = base;
    cfg.conv_mode = act_pkg::MODE_BURST;
    cfg.accumulate_count_field = 4'h2;
    conv(cfg);
    chk(nsamp - n0, 16'h0004);
    chk({5'h00, sidx}, 16'h0003);
    off();
    // Burst with amplifier needs a long enough sample duration
    cfg = base;
    cfg.conv_mode = act_pkg::MODE_BURST;
    cfg.amp_enable = 1'b1;
    cfg.sample_duration_field = 8'h0C;
    cfg.accumulate_count_field = 4'h1;
    conv(cfg);
    chk(nsamp - n0, 16'h0002);
    chk_rng(len[1], 26, 27);
    off();
    // Series mode takes one trigger per sample
    cfg = base;
    cfg.conv_mode = act_pkg::MODE_SERIES;
    cfg.accumulate_count_field = 4'h1;
    n0 = nsamp;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(150);
    chk({5'h00, sidx}, 16'h0001);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    wait_res();
    chk(nsamp - n0, 16'h0002);
    off();
    cfg = base;
    cfg.continuous_restart_bit = 1'b1;
    cfg.amp_enable = 1'b1;
    cfg.input_source = 2'h1;
    conv(cfg);
    tick(1);
    chk(busy, 1'b1);
    chk(ana.amp_power, 1'b1);
    chk(ana.src_power, 1'b1);
    off();
    cfg = base;
    cfg.low_latency_keep_on = 1'b1;
    cfg.ref_select = 3'h1;
    wait_busy();
    chk_us(len[0], 60);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    chk(ana.sampling, 1'b1);
    chk(busy, 1'b0);
    wait_res();
    tick(2);
    chk(ana.core_power, 1'b1);
    chk(ana.ref_power, 1'b1);
    cfg.ref_select = 3'h2;
    wait_busy();
    chk_us(len[0], 2);
    off();
    stop_test();
  end
  // Whole sequence needs well under 20000 clocks
  initial begin
    #2000000;
    n_errors++;
    stop_test();
  end
endmodule // act_conv_timing_tb
